//--- rtl/ngc_ctrl_regs.sv
// Control register bank: nonvolatile programming, pin output levels, cell enables
//
// What this block does
// - Bit 1 of the programming control register picks page one when zero and page two when one.
// - Writing one to bit 0 starts programming the selected page, only when both unlock codes hold.
// - Bits 0 to 5 of the pin output register set pins one to six low for zero, high for one.
// - A pin level bit reaches its pin only while that pin is configured as an output.
// - Bits 0 to 5 of the cell conversion register enable channels one to six when set.
// - Each channel's input level shifter is on exactly while its enable bit is one.
// - Channel enables are sampled for conversion only when the conversion start is written.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ngc_params.svh"

module ngc_ctrl_regs (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire ngc_pkg::ngc_bus_s bus_in,
  output logic [7:0]             rdata_out,
  input  wire logic              unlock_first_ok_in,
  input  wire logic              unlock_second_ok_in,
  output ngc_pkg::ngc_prog_s     prog_out,
  input  wire logic [5:0]        pin_is_output_in,
  input  wire logic [5:0]        pin_in_level_in,
  output logic [5:0]             pin_level_out,
  output logic [5:0]             pin_oe_out,
  input  wire logic              convert_start_in,
  output logic [5:0]             level_shift_on_out,
  output logic [5:0]             convert_chan_out
);

  // ==========================================
  // Address decode
  function automatic logic ngc_hit(input logic [8:0] a, input logic [8:0] off);
    ngc_hit = (a == off);
  endfunction

  logic       wr_prog;
  logic       wr_pin;
  logic       wr_cell;
  logic       page_reg;
  logic [5:0] pin_reg;
  logic [5:0] cell_reg;
  logic       unlocked;

  assign wr_prog  = bus_in.wr && ngc_hit(bus_in.addr, `NGC_OFF_PROG_CTRL);
  assign wr_pin   = bus_in.wr && ngc_hit(bus_in.addr, `NGC_OFF_PIN_OUT);
  assign wr_cell  = bus_in.wr && ngc_hit(bus_in.addr, `NGC_OFF_CELL_EN);
  assign unlocked = unlock_first_ok_in && unlock_second_ok_in;

  // ==========================================
  // Programming control
  // Page select held; start is a one-cycle pulse, so it reads back zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      page_reg <= 1'b0;
    end else if (wr_prog) begin
      page_reg <= bus_in.wdata[`NGC_BIT_PAGE_SEL];
    end
  end

  // Start refused silently when either unlock code is missing
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prog_out <= '0;
    end else begin
      prog_out.start <= wr_prog && bus_in.wdata[`NGC_BIT_PROG_START] && unlocked;
      prog_out.page  <= wr_prog ? bus_in.wdata[`NGC_BIT_PAGE_SEL] : page_reg;
    end
  end

  // ==========================================
  // Pin output levels
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_reg <= 6'h00;
    end else if (wr_pin) begin
      pin_reg <= bus_in.wdata[5:0];
    end
  end

  // Only pins configured as outputs are driven; others stay released
  genvar g;
  generate
    for (g = 0; g < `NGC_NUM_CH; g++) begin : g_pin
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          pin_level_out[g] <= 1'b0;
          pin_oe_out[g]    <= 1'b0;
        end else begin
          pin_level_out[g] <= pin_is_output_in[g] & pin_reg[g];
          pin_oe_out[g]    <= pin_is_output_in[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // Cell conversion enables
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cell_reg <= 6'h00;
    end else if (wr_cell) begin
      cell_reg <= bus_in.wdata[5:0];
    end
  end

  // Level shifters follow the live enable bits
  assign level_shift_on_out = cell_reg;

  // Converter set snapshot taken only on a start write
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      convert_chan_out <= 6'h00;
    end else if (convert_start_in) begin
      convert_chan_out <= cell_reg;
    end
  end

  // ==========================================
  // Read port; reserved bits and unmapped addresses read zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      if (ngc_hit(bus_in.addr, `NGC_OFF_PROG_CTRL)) begin
        rdata_out <= {6'h00, page_reg, 1'b0};
      end else if (ngc_hit(bus_in.addr, `NGC_OFF_PIN_OUT)) begin
        rdata_out <= {2'b00, pin_reg};
      end else if (ngc_hit(bus_in.addr, `NGC_OFF_CELL_EN)) begin
        rdata_out <= {2'b00, cell_reg};
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================
  // Checks
  property p_start_needs_unlock;
    @(posedge mclk_in) disable iff (reset_in)
      prog_out.start |-> $past(unlocked) && $past(wr_prog);
  endproperty
  a_start_needs_unlock: assert property (p_start_needs_unlock)
    else $error("program start without unlock");

  property p_start_taken;
    @(posedge mclk_in) disable iff (reset_in)
      wr_prog && bus_in.wdata[`NGC_BIT_PROG_START] && unlocked |=> prog_out.start;
  endproperty
  a_start_taken: assert property (p_start_taken)
    else $error("unlocked start lost");

  property p_page_sel;
    @(posedge mclk_in) disable iff (reset_in)
      wr_prog |=> prog_out.page == $past(bus_in.wdata[`NGC_BIT_PAGE_SEL]);
  endproperty
  a_page_sel: assert property (p_page_sel)
    else $error("page select wrong");

  property p_pin_level;
    @(posedge mclk_in) disable iff (reset_in)
      wr_pin ##1 1'b1 |=> pin_level_out == ($past(pin_reg) & $past(pin_is_output_in));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("pin level mismatch");

  property p_pin_release;
    @(posedge mclk_in) disable iff (reset_in)
      !pin_is_output_in[0] |=> !pin_oe_out[0] && !pin_level_out[0];
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("input pin driven");

  property p_cell_write;
    @(posedge mclk_in) disable iff (reset_in)
      wr_cell |=> level_shift_on_out == $past(bus_in.wdata[5:0]);
  endproperty
  a_cell_write: assert property (p_cell_write)
    else $error("cell enable not stored");

  property p_shift_follow;
    @(posedge mclk_in) disable iff (reset_in)
      !wr_cell |=> $stable(level_shift_on_out);
  endproperty
  a_shift_follow: assert property (p_shift_follow)
    else $error("level shifter out of step");

  property p_snapshot_hold;
    @(posedge mclk_in) disable iff (reset_in)
      !convert_start_in |=> $stable(convert_chan_out);
  endproperty
  a_snapshot_hold: assert property (p_snapshot_hold)
    else $error("conversion set changed without start");

  property p_rsvd_zero;
    @(posedge mclk_in) disable iff (reset_in)
      bus_in.rd |=> rdata_out[7:6] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_start_refused;
    @(posedge mclk_in) disable iff (reset_in)
      wr_prog && !unlocked |=> !prog_out.start;
  endproperty
  a_start_refused: assert property (p_start_refused)
    else $error("locked start not refused");

  property p_prog_readback;
    @(posedge mclk_in) disable iff (reset_in)
      bus_in.rd && ngc_hit(bus_in.addr, `NGC_OFF_PROG_CTRL)
        |=> rdata_out == {6'h00, $past(page_reg), 1'b0};
  endproperty
  a_prog_readback: assert property (p_prog_readback)
    else $error("programming control readback wrong");

  property p_oe_follow;
    @(posedge mclk_in) disable iff (reset_in)
      1'b1 |=> pin_oe_out == $past(pin_is_output_in);
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("pin drive enable out of step");

  property p_snapshot_take;
    @(posedge mclk_in) disable iff (reset_in)
      convert_start_in |=> convert_chan_out == $past(cell_reg);
  endproperty
  a_snapshot_take: assert property (p_snapshot_take)
    else $error("conversion set not taken at start");

endmodule

//--- rtl/ngc_params.svh
// Register offsets, field positions and reset values of the control bank
`ifndef NGC_PARAMS_SVH
`define NGC_PARAMS_SVH
`define NGC_ADDR_W          9
`define NGC_OFF_PROG_CTRL   9'h107
`define NGC_OFF_PIN_OUT     9'h108
`define NGC_OFF_CELL_EN     9'h109
`define NGC_BIT_PROG_START  0
`define NGC_BIT_PAGE_SEL    1
`define NGC_RST_PROG_CTRL   8'h00
`define NGC_RST_PIN_OUT     8'h00
`define NGC_RST_CELL_EN     8'h00
`define NGC_MASK_PROG_CTRL  8'h03
`define NGC_MASK_SIX        8'h3f
`define NGC_NUM_CH          6
`endif

//--- rtl/ngc_pkg.sv
// Types shared by the control register bank
package ngc_pkg;
  // Register bus request
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ngc_bus_s;
  // Programming request toward the nonvolatile engine
  typedef struct packed {
    logic page;
    logic start;
  } ngc_prog_s;
endpackage

//--- bench/testbench.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`include "ngc_params.svh"

module testbench;
  // ==========================================================
  // Stimulus and observed signals
  logic               mclk_in  = 1'b0;
  logic               reset_in = 1'b1;
  ngc_pkg::ngc_bus_s  bus      = '0;
  logic               unl1     = 1'b0;
  logic               unl2     = 1'b0;
  logic [5:0]         pin_dir  = 6'h00;
  logic               cstart   = 1'b0;
  logic [7:0]         rdata;
  ngc_pkg::ngc_prog_s prog;
  logic [5:0]         pin_lvl;
  logic [5:0]         pin_oe;
  logic [5:0]         shift_on;
  logic [5:0]         chan;
  integer             bad_count   = 0;
  integer             check_count = 0;
  // Rows: address, write data, expected readback
  logic [24:0]        rows [4] = '{{9'h108, 8'hff, 8'h3f}, {9'h109, 8'hff, 8'h3f},
                                   {9'h107, 8'h02, 8'h02}, {9'h10a, 8'hff, 8'h00}};

  ngc_ctrl_regs i_dut (
    .mclk_in             (mclk_in),
    .reset_in            (reset_in),
    .bus_in              (bus),
    .rdata_out           (rdata),
    .unlock_first_ok_in  (unl1),
    .unlock_second_ok_in (unl2),
    .prog_out            (prog),
    .pin_is_output_in    (pin_dir),
    .pin_in_level_in     (6'h00),
    .pin_level_out       (pin_lvl),
    .pin_oe_out          (pin_oe),
    .convert_start_in    (cstart),
    .level_shift_on_out  (shift_on),
    .convert_chan_out    (chan)
  );

  // ==========================================================
  // Clock, 50 ns period
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far beyond the under one hundred cycles the run needs
  initial begin
    #200us;
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_in);
    #1 chk({2'h0, pin_oe}, 8'h00);
    reset_in <= 1'b0;
    rd(`NGC_OFF_PROG_CTRL, 8'h00);
    rd(`NGC_OFF_PIN_OUT, 8'h00);
    rd(`NGC_OFF_CELL_EN, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][24:16], rows[i][15:8]);
      rd(rows[i][24:16], rows[i][7:0]);
    end
    // Pin levels only reach pins configured as outputs
    wr(`NGC_OFF_PIN_OUT, 8'h2d);
    pin_dir <= 6'h0f;
    cyc(2);
    chk({2'h0, pin_lvl}, 8'h0d);
    chk({2'h0, pin_oe}, 8'h0f);
    pin_dir <= 6'h30;
    cyc(2);
    chk({2'h0, pin_lvl}, 8'h20);
    chk({2'h0, pin_oe}, 8'h30);
    // Shifters follow the enables live, conversion only at start
    wr(`NGC_OFF_CELL_EN, 8'h15);
    cyc(1);
    chk({2'h0, shift_on}, 8'h15);
    cstart <= 1'b1;
    @(posedge mclk_in);
    cstart <= 1'b0;
    #1 chk({2'h0, chan}, 8'h15);
    wr(`NGC_OFF_CELL_EN, 8'h2a);
    cyc(2);
    chk({2'h0, chan}, 8'h15);
    chk({2'h0, shift_on}, 8'h2a);
    // Programming refused with either unlock missing
    unl1 <= 1'b1;
    wr(`NGC_OFF_PROG_CTRL, 8'h01);
    #1 chk({6'h0, prog}, 8'h00);
    unl1 <= 1'b0;
    unl2 <= 1'b1;
    wr(`NGC_OFF_PROG_CTRL, 8'h01);
    #1 chk({6'h0, prog}, 8'h00);
    // Both unlocks: one start pulse for page two, then page one
    unl1 <= 1'b1;
    wr(`NGC_OFF_PROG_CTRL, 8'h03);
    #1 chk({6'h0, prog}, 8'h03);
    cyc(1);
    chk({7'h0, prog.start}, 8'h00);
    wr(`NGC_OFF_PROG_CTRL, 8'h01);
    #1 chk({6'h0, prog}, 8'h01);
    rd(`NGC_OFF_PROG_CTRL, 8'h00);
    // Page two left selected so the mid-run reset has something to clear
    wr(`NGC_OFF_PROG_CTRL, 8'h02);
    #1 chk({6'h0, prog}, 8'h02);
    // Second reset in mid-run
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    chk({2'h0, shift_on}, 8'h00);
    chk({2'h0, chan}, 8'h00);
    chk({6'h0, prog}, 8'h00);
    rd(`NGC_OFF_CELL_EN, 8'h00);
    rd(`NGC_OFF_PIN_OUT, 8'h00);
    rd(`NGC_OFF_PROG_CTRL, 8'h00);
    end_sim();
  end
endmodule
